// >>> core/delay_mode_ctrl.sv
// mode controller of a stereo broadcast profanity delay
// Notes on behaviour
// - after reset: bypass, relay through, delay zero
// - bypass press while bypassed goes in-line, static (precision if selected), zero delay
// - shrink mode lowers delay slowly, static at zero
// - arming fills buffer, live output, lamp flashes; growth at safe
// - cough blocks input, output plays on, prior mode on release
// - drain blocks input, ignores cough, static at zero
// - grow press starts slow growth, lamp flashes while growing
// - in-line at or above safe lights cut lamp and safe relay
// - at maximum growth lamp off but mode stays growth
// - shrink lamp flashes; second shrink press halts into static
// - drain press starts drain, lamp flashes, live at zero
// - second drain press cancels, restores old delay, static
// - cut in grow or shrink subtracts cut amount, clamps at zero
// - cut held keeps delay; release resumes prior mode
// - cut in config or precision mode enters bypass
// - cut during arming aborts it, delay left zero
// - cut ignored in bypass, live and drain
// - cough only in-line profanity mode, not arming or drain
// - zero delay while cough held mutes output
// - bar graph lights delay over maximum of 15 segments
// - display shows seconds at chosen resolution; bypass shows safe
// - delay bounded by 20 or 40 second buffer
`timescale 1ns/1ps
module delay_mode_ctrl #(
  parameter int DEBOUNCE_CYCLES = delay_ctrl_pkg::DEBOUNCE_CYCLES,
  parameter int FLASH_CYCLES = delay_ctrl_pkg::FLASH_CYCLES,
  parameter int W = delay_ctrl_pkg::DELAY_W,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [delay_ctrl_pkg::BTN_COUNT-1:0] button_n_i,
  input wire logic config_exit_i,
  input wire logic precision_sel_i,
  input wire logic extended_buffer_i,
  input wire logic safe_relay_en_i,
  input wire logic [1:0] resolution_i,
  input wire logic [W-1:0] max_delay_i,
  input wire logic [W-1:0] safe_delay_i,
  input wire logic [W-1:0] cut_amount_i,
  input wire logic [W-1:0] grow_step_i,
  input wire logic [W-1:0] shrink_step_i,
  input wire logic sample_tick_i,
  output logic bypass_relay_o,
  output logic write_enable_o,
  output logic read_enable_o,
  output logic output_live_o,
  output logic output_mute_o,
  output logic [W-1:0] delay_o,
  output logic [3:0] mode_o,
  output logic [delay_ctrl_pkg::BTN_COUNT-1:0] lamp_o,
  output logic safe_relay_o,
  output logic [3:0] bar_count_o,
  output logic [delay_ctrl_pkg::CENTI_W-1:0] display_value_o,
  output logic [1:0] display_point_o,
  output logic display_blank_o,
  output logic cut_valid_o,
  input wire logic cut_ready_i,
  output logic [W-1:0] cut_data_o
);
  localparam int N = delay_ctrl_pkg::BTN_COUNT;
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int FW = $clog2(FLASH_CYCLES + 1);
  localparam int PW = W + 8;

  // ---------------------------------------------------------------
  // button synchronise and debounce
  // ---------------------------------------------------------------
  logic [N-1:0] btn_meta;
  logic [N-1:0] btn_sync;
  logic [N-1:0] btn_stable;
  logic [N-1:0] btn_prev;
  logic [N-1:0] press;
  logic [N-1:0] release_ev;
  logic [CW-1:0] db_cnt [N];

  // two-flop synchroniser, buttons active low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      btn_meta <= '0;
      btn_sync <= '0;
    end else begin
      btn_meta <= ~button_n_i;
      btn_sync <= btn_meta;
    end
  end

  // per-button settle counter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      btn_stable <= '0;
      btn_prev <= '0;
      for (int i = 0; i < N; i++) db_cnt[i] <= '0;
    end else begin
      btn_prev <= btn_stable;
      for (int i = 0; i < N; i++) begin
        if (btn_sync[i] == btn_stable[i]) begin
          db_cnt[i] <= '0;
        end else if (db_cnt[i] == CW'(DEBOUNCE_CYCLES - 1)) begin
          btn_stable[i] <= btn_sync[i];
          db_cnt[i] <= '0;
        end else begin
          db_cnt[i] <= db_cnt[i] + 1'b1;
        end
      end
    end
  end

  assign press = btn_stable & ~btn_prev;
  assign release_ev = ~btn_stable & btn_prev;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [W-1:0] sat_sub(input logic [W-1:0] a,
                                           input logic [W-1:0] b);
    sat_sub = (a > b) ? a - b : '0;
  endfunction : sat_sub

  function automatic logic [W-1:0] sat_add(input logic [W-1:0] a,
                                           input logic [W-1:0] b,
                                           input logic [W-1:0] lim);
    sat_add = (lim - a > b) ? a + b : lim;
  endfunction : sat_add

  // effective maximum, bounded by buffer size
  logic [W-1:0] buf_limit;
  logic [W-1:0] max_eff;
  assign buf_limit = extended_buffer_i ?
    W'(delay_ctrl_pkg::MAX_SAMPLES_EXT) : W'(delay_ctrl_pkg::MAX_SAMPLES);
  assign max_eff = (max_delay_i > buf_limit) ?
    buf_limit : max_delay_i;

  // ---------------------------------------------------------------
  // mode state machine
  // ---------------------------------------------------------------
  delay_ctrl_pkg::mode_e mode;
  delay_ctrl_pkg::mode_e resume_mode;
  logic [W-1:0] delay;
  logic [W-1:0] drain_saved;
  logic cut_push;
  logic live;

  // live means in-line with zero delay and nothing moving
  assign live = (mode == delay_ctrl_pkg::MODE_STATIC) && (delay == '0);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode <= delay_ctrl_pkg::MODE_BYPASS;
      resume_mode <= delay_ctrl_pkg::MODE_STATIC;
      delay <= '0;
      drain_saved <= '0;
      cut_push <= 1'b0;
    end else begin
      cut_push <= 1'b0;
      case (mode)
        delay_ctrl_pkg::MODE_BYPASS: begin
          delay <= '0;
          if (press[delay_ctrl_pkg::BTN_BYPASS]) begin
            mode <= precision_sel_i ? delay_ctrl_pkg::MODE_PRECISION :
                                      delay_ctrl_pkg::MODE_STATIC;
          end else if (press[delay_ctrl_pkg::BTN_CONFIG]) begin
            mode <= delay_ctrl_pkg::MODE_CONFIG;
          end
        end
        delay_ctrl_pkg::MODE_CONFIG, delay_ctrl_pkg::MODE_PRECISION: begin
          delay <= '0;
          if (press[delay_ctrl_pkg::BTN_CUT] || config_exit_i ||
              press[delay_ctrl_pkg::BTN_BYPASS]) begin
            mode <= delay_ctrl_pkg::MODE_BYPASS;
          end
        end
        delay_ctrl_pkg::MODE_STATIC, delay_ctrl_pkg::MODE_GROW,
        delay_ctrl_pkg::MODE_SHRINK: begin
          if (press[delay_ctrl_pkg::BTN_BYPASS]) begin
            mode <= delay_ctrl_pkg::MODE_BYPASS;
            delay <= '0;
          end else if (press[delay_ctrl_pkg::BTN_CUT] && !live &&
                       mode != delay_ctrl_pkg::MODE_STATIC) begin
            resume_mode <= mode;
            mode <= delay_ctrl_pkg::MODE_CUT;
            delay <= sat_sub(delay, cut_amount_i);
            cut_push <= 1'b1;
          end else if (press[delay_ctrl_pkg::BTN_COUGH]) begin
            resume_mode <= mode;
            mode <= delay_ctrl_pkg::MODE_COUGH;
          end else if (press[delay_ctrl_pkg::BTN_DRAIN] && delay != '0) begin
            drain_saved <= delay;
            mode <= delay_ctrl_pkg::MODE_DRAIN;
          end else if (press[delay_ctrl_pkg::BTN_GROW]) begin
            mode <= delay_ctrl_pkg::MODE_GROW;
          end else if (press[delay_ctrl_pkg::BTN_ARM] && delay == '0) begin
            mode <= delay_ctrl_pkg::MODE_ARM;
          end else if (press[delay_ctrl_pkg::BTN_SHRINK]) begin
            mode <= (mode == delay_ctrl_pkg::MODE_SHRINK) ?
              delay_ctrl_pkg::MODE_STATIC :
              delay_ctrl_pkg::MODE_SHRINK;
          end else if (mode == delay_ctrl_pkg::MODE_GROW &&
                       sample_tick_i) begin
            delay <= sat_add(delay, grow_step_i, max_eff);
          end else if (mode == delay_ctrl_pkg::MODE_SHRINK &&
                       sample_tick_i) begin
            delay <= sat_sub(delay, shrink_step_i);
            if (delay <= shrink_step_i) begin
              mode <= delay_ctrl_pkg::MODE_STATIC;
            end
          end
        end
        delay_ctrl_pkg::MODE_ARM: begin
          if (press[delay_ctrl_pkg::BTN_BYPASS]) begin
            mode <= delay_ctrl_pkg::MODE_BYPASS;
            delay <= '0;
          end else if (press[delay_ctrl_pkg::BTN_CUT]) begin
            mode <= delay_ctrl_pkg::MODE_STATIC;
            delay <= '0;
          end else if (delay >= safe_delay_i) begin
            mode <= delay_ctrl_pkg::MODE_GROW;
          end else if (sample_tick_i) begin
            delay <= delay + 1'b1;
          end
        end
        delay_ctrl_pkg::MODE_COUGH: begin
          if (press[delay_ctrl_pkg::BTN_BYPASS]) begin
            mode <= delay_ctrl_pkg::MODE_BYPASS;
            delay <= '0;
          end else if (release_ev[delay_ctrl_pkg::BTN_COUGH]) begin
            mode <= resume_mode;
          end else if (sample_tick_i && delay != '0) begin
            delay <= delay - 1'b1;
          end
        end
        delay_ctrl_pkg::MODE_DRAIN: begin
          if (press[delay_ctrl_pkg::BTN_BYPASS]) begin
            mode <= delay_ctrl_pkg::MODE_BYPASS;
            delay <= '0;
          end else if (press[delay_ctrl_pkg::BTN_DRAIN]) begin
            delay <= drain_saved;
            mode <= delay_ctrl_pkg::MODE_STATIC;
          end else if (delay == '0) begin
            mode <= delay_ctrl_pkg::MODE_STATIC;
          end else if (sample_tick_i) begin
            delay <= delay - 1'b1;
          end
        end
        delay_ctrl_pkg::MODE_CUT: begin
          if (press[delay_ctrl_pkg::BTN_BYPASS]) begin
            mode <= delay_ctrl_pkg::MODE_BYPASS;
            delay <= '0;
          end else if (release_ev[delay_ctrl_pkg::BTN_CUT]) begin
            mode <= resume_mode;
          end
        end
        default: begin
          mode <= delay_ctrl_pkg::MODE_BYPASS;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // cut command fifo to the datapath
  // ---------------------------------------------------------------
  delay_event_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_cut_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(cut_push),
    .in_ready_o(),
    .in_data_i(cut_amount_i),
    .out_valid_o(cut_valid_o),
    .out_ready_i(cut_ready_i),
    .out_data_o(cut_data_o)
  );

  // ---------------------------------------------------------------
  // flash divider
  // ---------------------------------------------------------------
  logic [FW-1:0] flash_cnt;
  logic flash;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flash_cnt <= '0;
      flash <= 1'b0;
    end else if (flash_cnt == FW'(FLASH_CYCLES - 1)) begin
      flash_cnt <= '0;
      flash <= ~flash;
    end else begin
      flash_cnt <= flash_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // audio path controls, relays and lamps
  // ---------------------------------------------------------------
  logic inline_on;
  logic at_safe;
  assign inline_on = (mode != delay_ctrl_pkg::MODE_BYPASS) &&
                     (mode != delay_ctrl_pkg::MODE_CONFIG);
  assign at_safe = inline_on && (delay >= safe_delay_i) &&
                   (mode != delay_ctrl_pkg::MODE_PRECISION);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bypass_relay_o <= 1'b1;
      write_enable_o <= 1'b0;
      read_enable_o <= 1'b0;
      output_live_o <= 1'b1;
      output_mute_o <= 1'b0;
      safe_relay_o <= 1'b0;
      lamp_o <= '0;
      delay_o <= '0;
      mode_o <= 4'h0;
    end else begin
      bypass_relay_o <= !inline_on;
      write_enable_o <= inline_on &&
                        (mode != delay_ctrl_pkg::MODE_COUGH) &&
                        (mode != delay_ctrl_pkg::MODE_DRAIN);
      read_enable_o <= inline_on && (mode != delay_ctrl_pkg::MODE_ARM);
      output_live_o <= !inline_on || (mode == delay_ctrl_pkg::MODE_ARM) ||
                       live;
      output_mute_o <= (mode == delay_ctrl_pkg::MODE_COUGH) &&
                       (delay == '0);
      safe_relay_o <= at_safe && safe_relay_en_i;
      lamp_o <= '0;
      lamp_o[delay_ctrl_pkg::BTN_BYPASS] <= !inline_on;
      lamp_o[delay_ctrl_pkg::BTN_CUT] <= at_safe;
      lamp_o[delay_ctrl_pkg::BTN_GROW] <= (mode == delay_ctrl_pkg::MODE_GROW)
        && (delay < max_eff) && flash;
      lamp_o[delay_ctrl_pkg::BTN_SHRINK] <=
        (mode == delay_ctrl_pkg::MODE_SHRINK) && flash;
      lamp_o[delay_ctrl_pkg::BTN_ARM] <=
        (mode == delay_ctrl_pkg::MODE_ARM) && flash;
      lamp_o[delay_ctrl_pkg::BTN_DRAIN] <=
        (mode == delay_ctrl_pkg::MODE_DRAIN) && flash;
      lamp_o[delay_ctrl_pkg::BTN_COUGH] <= inline_on &&
        (mode != delay_ctrl_pkg::MODE_ARM) &&
        (mode != delay_ctrl_pkg::MODE_DRAIN) &&
        (mode != delay_ctrl_pkg::MODE_PRECISION);
      delay_o <= delay;
      mode_o <= mode;
    end
  end

  // ---------------------------------------------------------------
  // bar graph and numeric display
  // ---------------------------------------------------------------
  logic [PW-1:0] bar_prod;
  logic [PW-1:0] bar_q;
  logic [W-1:0] shown;
  logic [PW-1:0] centi_prod;
  logic [PW-1:0] centi;
  logic [delay_ctrl_pkg::CENTI_W-1:0] centi_n;

  assign bar_prod = PW'(delay) * PW'(delay_ctrl_pkg::BAR_SEGMENTS);
  assign bar_q = (max_eff == '0) ? '0 : bar_prod / PW'(max_eff);
  assign shown = inline_on ? delay : safe_delay_i;
  assign centi_prod = PW'(shown) * PW'(100);
  assign centi = centi_prod / PW'(delay_ctrl_pkg::SAMPLE_HZ);
  assign centi_n = delay_ctrl_pkg::CENTI_W'(centi);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bar_count_o <= 4'h0;
      display_value_o <= '0;
      display_point_o <= 2'h0;
      display_blank_o <= 1'b0;
    end else begin
      bar_count_o <= (bar_q > PW'(delay_ctrl_pkg::BAR_SEGMENTS)) ?
        4'(delay_ctrl_pkg::BAR_SEGMENTS) : 4'(bar_q);
      display_blank_o <= (resolution_i == delay_ctrl_pkg::RES_BLANK);
      case (resolution_i)
        delay_ctrl_pkg::RES_ONE: begin
          display_value_o <= centi_n / 14'h0064;
          display_point_o <= 2'h0;
        end
        delay_ctrl_pkg::RES_TWO: begin
          display_value_o <= centi_n / 14'h000A;
          display_point_o <= 2'h1;
        end
        default: begin
          display_value_o <= centi_n;
          display_point_o <= 2'h2;
        end
      endcase
    end
  end
endmodule : delay_mode_ctrl

// >>> shared/delay_ctrl_pkg.sv
// constants and types shared by the delay mode controller
package delay_ctrl_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_MS;
  // ---------------------------------------------------------------
  // delay figures in audio samples at the default rate
  // ---------------------------------------------------------------
  localparam int SAMPLE_HZ = 48000;
  localparam int BUFFER_SECONDS = 20;
  localparam int BUFFER_SECONDS_EXT = 40;
  localparam int DELAY_W = 22;
  localparam int MAX_SAMPLES = SAMPLE_HZ * BUFFER_SECONDS;
  localparam int MAX_SAMPLES_EXT = SAMPLE_HZ * BUFFER_SECONDS_EXT;
  localparam int SAFE_CENTI = 400;
  localparam int CUT_CENTI = 300;
  localparam int SAFE_SAMPLES = SAMPLE_HZ * SAFE_CENTI / 100;
  localparam int CUT_SAMPLES = SAMPLE_HZ * CUT_CENTI / 100;
  localparam int BAR_SEGMENTS = 15;
  localparam int CENTI_W = 14;
  // ---------------------------------------------------------------
  // button indices
  // ---------------------------------------------------------------
  localparam int BTN_COUNT = 8;
  localparam int BTN_BYPASS = 0;
  localparam int BTN_GROW = 1;
  localparam int BTN_SHRINK = 2;
  localparam int BTN_ARM = 3;
  localparam int BTN_DRAIN = 4;
  localparam int BTN_COUGH = 5;
  localparam int BTN_CUT = 6;
  localparam int BTN_CONFIG = 7;
  // ---------------------------------------------------------------
  // display resolution codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RES_BLANK = 2'h0;
  localparam logic [1:0] RES_ONE = 2'h1;
  localparam logic [1:0] RES_TWO = 2'h2;
  localparam logic [1:0] RES_THREE = 2'h3;
  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_BYPASS = 4'h0,
    MODE_CONFIG = 4'h1,
    MODE_PRECISION = 4'h2,
    MODE_STATIC = 4'h3,
    MODE_GROW = 4'h4,
    MODE_SHRINK = 4'h5,
    MODE_ARM = 4'h6,
    MODE_COUGH = 4'h7,
    MODE_DRAIN = 4'h8,
    MODE_CUT = 4'h9
  } mode_e;
endpackage : delay_ctrl_pkg

// >>> core/delay_event_fifo.sv
// fifo holding delay edit commands toward the audio datapath
`timescale 1ns/1ps
module delay_event_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign push = in_valid_i && in_ready_o;
  // move a word out when the output register is empty or being taken
  assign pop = (count != '0) && (!out_valid_o || out_ready_i);

  // output register, valid and data leave straight from flip-flops
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (!out_valid_o || out_ready_i) begin
      out_valid_o <= (count != '0);
      out_data_o <= mem[rd_ptr];
    end
  end

  // storage and pointers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : delay_event_fifo

// >>> test/delay_mode_ctrl_properties.sv
// port checker for the delay mode controller
`timescale 1ns/1ps
module delay_mode_ctrl_properties #(
  parameter int W = 22
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic safe_relay_en_i,
  input wire logic [W-1:0] max_delay_i,
  input wire logic [W-1:0] safe_delay_i,
  input wire logic bypass_relay_o,
  input wire logic write_enable_o,
  input wire logic read_enable_o,
  input wire logic output_live_o,
  input wire logic output_mute_o,
  input wire logic [W-1:0] delay_o,
  input wire logic [3:0] mode_o,
  input wire logic [delay_ctrl_pkg::BTN_COUNT-1:0] lamp_o,
  input wire logic safe_relay_o,
  input wire logic [3:0] bar_count_o
);
  // ----------
  // mode checks
  // ----------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // mode_o and the other outputs move on the same edge
  a_reset_bypass: assert property (
    $fell(reset_i) |-> mode_o == delay_ctrl_pkg::MODE_BYPASS
      && bypass_relay_o && delay_o == '0)
    else $error("not bypassed after reset");
  a_static_inline: assert property (
    mode_o == delay_ctrl_pkg::MODE_STATIC |-> !bypass_relay_o)
    else $error("relay bypassing in static");
  a_arm_fill: assert property (
    mode_o == delay_ctrl_pkg::MODE_ARM |-> write_enable_o && output_live_o)
    else $error("arming not filling with live output");
  a_cough_block: assert property (
    mode_o == delay_ctrl_pkg::MODE_COUGH |-> !write_enable_o && read_enable_o)
    else $error("cough still writing");
  a_cough_mute: assert property (
    mode_o == delay_ctrl_pkg::MODE_COUGH && delay_o == '0 |-> output_mute_o)
    else $error("no mute at zero delay");
  a_safe_lamp: assert property (
    mode_o > 4'h2 && delay_o >= safe_delay_i && safe_relay_en_i
      |-> lamp_o[delay_ctrl_pkg::BTN_CUT] && safe_relay_o)
    else $error("safe indication missing");
  a_grow_cap: assert property (
    mode_o == delay_ctrl_pkg::MODE_GROW && delay_o == max_delay_i
      |-> !lamp_o[delay_ctrl_pkg::BTN_GROW])
    else $error("grow lamp on at maximum");
  a_cut_hold: assert property (
    mode_o == delay_ctrl_pkg::MODE_CUT ##1 mode_o == delay_ctrl_pkg::MODE_CUT
      |-> $stable(delay_o))
    else $error("delay moved while cut held");
  a_bar_full: assert property (
    delay_o == max_delay_i && delay_o != '0 |-> bar_count_o == 4'hF)
    else $error("bar not full at maximum");
endmodule : delay_mode_ctrl_properties
bind delay_mode_ctrl delay_mode_ctrl_properties #(.W(W)) u_props (.*);

// >>> test/delay_datapath_model.sv
// audio datapath stand-in: sample ticks and cut command sink
`timescale 1ns/1ps
module delay_datapath_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic stall_i,
  input wire logic cut_valid_i,
  input wire logic [21:0] cut_data_i,
  output logic sample_tick_o,
  output logic cut_ready_o,
  output logic [21:0] last_cut_o
);
  // one audio sample every other clock
  always_ff @(posedge clk_i) begin
    sample_tick_o <= reset_i ? 1'b0 : !sample_tick_o;
  end
  // take cut commands unless stalled
  assign cut_ready_o = !stall_i;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      last_cut_o <= 22'h000000;
    end else if (cut_valid_i && cut_ready_o) begin
      last_cut_o <= cut_data_i;
    end
  end
endmodule : delay_datapath_model

// >>> test/tb_delay_mode_ctrl.sv
// self-checking bench for the delay mode controller
`timescale 1ns/1ps
`define CHK(a, e) begin \
  checks_done++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); \
  end \
end
module tb_delay_mode_ctrl;
  localparam int W = delay_ctrl_pkg::DELAY_W;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] button_n_i = 8'hFF;
  logic config_exit_i = 1'b0;
  logic precision_sel_i = 1'b0;
  logic safe_relay_en_i = 1'b1;
  logic stall = 1'b0;
  logic extended_buffer_i;
  logic [1:0] resolution_i;
  logic [W-1:0] max_delay_i, safe_delay_i, cut_amount_i, grow_step_i;
  logic [W-1:0] shrink_step_i, delay_o, cut_data_o, last_cut, d;
  logic sample_tick_i, cut_ready_i, bypass_relay_o, write_enable_o;
  logic read_enable_o, output_live_o, output_mute_o, safe_relay_o;
  logic display_blank_o, cut_valid_o;
  logic [3:0] mode_o, bar_count_o;
  logic [7:0] lamp_o;
  logic [13:0] display_value_o;
  logic [1:0] display_point_o;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_on;
  logic [16:0] disp;
  assign disp = {display_blank_o, display_point_o, display_value_o};
  // design with short debounce and flash counts
  delay_mode_ctrl #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8))
    u_delay_mode_ctrl (.*);
  delay_datapath_model u_delay_datapath_model (
    .clk_i(clk_i), .reset_i(reset_i), .stall_i(stall),
    .cut_valid_i(cut_valid_o), .cut_data_i(cut_data_o),
    .sample_tick_o(sample_tick_i), .cut_ready_o(cut_ready_i),
    .last_cut_o(last_cut));
  always #25 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  // button level held long enough to pass the debounce
  task automatic push(input int b, input logic lvl);
    button_n_i[b] = lvl;
    tick(12);
  endtask : push
  task automatic tap(input int b);
    push(b, 1'b0);
    push(b, 1'b1);
  endtask : tap
  task automatic wait_until(input logic [3:0] m, input logic [W-1:0] v);
    for (int i = 0; i < 3000; i++) begin
      if (mode_o === m && delay_o === v) break;
      tick(1);
    end
    `CHK({mode_o, delay_o}, {m, v})
  endtask : wait_until
  function automatic logic [W-1:0] after_cut(input logic [W-1:0] v);
    return (v > cut_amount_i) ? v - cut_amount_i : '0;
  endfunction : after_cut
  // expected blank flag, point position and value for a sample count
  function automatic logic [16:0] show_exp(input logic [1:0] r,
                                           input logic [W-1:0] s);
    int c;
    c = int'(s) * 100 / delay_ctrl_pkg::SAMPLE_HZ;
    if (r == 2'h1) return {1'b0, 2'h0, 14'(c / 100)};
    if (r == 2'h2) return {1'b0, 2'h1, 14'(c / 10)};
    return {r == 2'h0, 2'h2, 14'(c)};
  endfunction : show_exp
  // main sequence
  initial begin
    void'($urandom(93357));
    safe_delay_i = W'(40 + $urandom % 12);
    max_delay_i = safe_delay_i + W'(30 + $urandom % 20);
    cut_amount_i = W'(5 + $urandom % 8);
    grow_step_i = W'(1 + $urandom % 3);
    shrink_step_i = W'(1 + $urandom % 3);
    resolution_i = 2'($urandom);
    extended_buffer_i = 1'($urandom);
    tick(12);
    reset_i = 1'b0;
    tick(1);
    `CHK({mode_o, bypass_relay_o}, 5'h01)
    tap(delay_ctrl_pkg::BTN_CUT);
    wait_until(delay_ctrl_pkg::MODE_BYPASS, '0);
    tap(delay_ctrl_pkg::BTN_CONFIG);
    `CHK(mode_o, 4'h1)
    tap(delay_ctrl_pkg::BTN_CUT);
    wait_until(delay_ctrl_pkg::MODE_BYPASS, '0);
    precision_sel_i = 1'b1;
    tap(delay_ctrl_pkg::BTN_BYPASS);
    `CHK({mode_o, bypass_relay_o}, 5'h4)
    tap(delay_ctrl_pkg::BTN_CUT);
    precision_sel_i = 1'b0;
    wait_until(delay_ctrl_pkg::MODE_BYPASS, '0);
    tap(delay_ctrl_pkg::BTN_BYPASS);
    wait_until(delay_ctrl_pkg::MODE_STATIC, '0);
    push(delay_ctrl_pkg::BTN_COUGH, 1'b0);
    `CHK(output_mute_o, 1'b1)
    push(delay_ctrl_pkg::BTN_COUGH, 1'b1);
    wait_until(delay_ctrl_pkg::MODE_STATIC, '0);
    tap(delay_ctrl_pkg::BTN_ARM);
    `CHK({mode_o, output_live_o}, 5'hD)
    wait_until(delay_ctrl_pkg::MODE_GROW, max_delay_i);
    tick(2);
    `CHK({safe_relay_o, lamp_o[6]}, 2'h3)
    `CHK(bar_count_o, 4'hF)
    stall = 1'b1;
    push(delay_ctrl_pkg::BTN_CUT, 1'b0);
    `CHK(delay_o, after_cut(max_delay_i))
    `CHK(cut_valid_o, 1'b1)
    stall = 1'b0;
    tick(4);
    `CHK(last_cut, cut_amount_i)
    `CHK(delay_o, after_cut(max_delay_i))
    push(delay_ctrl_pkg::BTN_CUT, 1'b1);
    wait_until(delay_ctrl_pkg::MODE_GROW, max_delay_i);
    tap(delay_ctrl_pkg::BTN_SHRINK);
    `CHK(mode_o, 4'h5)
    tap(delay_ctrl_pkg::BTN_SHRINK);
    d = delay_o;
    tick(6);
    wait_until(delay_ctrl_pkg::MODE_STATIC, d);
    tap(delay_ctrl_pkg::BTN_DRAIN);
    `CHK({mode_o, write_enable_o}, 5'h10)
    tap(delay_ctrl_pkg::BTN_DRAIN);
    wait_until(delay_ctrl_pkg::MODE_STATIC, d);
    tap(delay_ctrl_pkg::BTN_DRAIN);
    wait_until(delay_ctrl_pkg::MODE_STATIC, '0);
    tick(2);
    `CHK(output_live_o, 1'b1)
    push(delay_ctrl_pkg::BTN_CUT, 1'b0);
    `CHK({mode_o, cut_valid_o}, 5'h6)
    push(delay_ctrl_pkg::BTN_CUT, 1'b1);
    tap(delay_ctrl_pkg::BTN_ARM);
    push(delay_ctrl_pkg::BTN_COUGH, 1'b0);
    `CHK({mode_o, output_mute_o}, 5'hC)
    push(delay_ctrl_pkg::BTN_COUGH, 1'b1);
    tap(delay_ctrl_pkg::BTN_CUT);
    `CHK({mode_o == 4'h6, delay_o}, {1'b0, W'(0)})
    tap(delay_ctrl_pkg::BTN_GROW);
    n_on = 0;
    repeat (12) begin
      tick(1);
      n_on += lamp_o[delay_ctrl_pkg::BTN_GROW];
    end
    `CHK(n_on > 0 && n_on < 12, 1'b1)
    tick(16);
    tap(delay_ctrl_pkg::BTN_SHRINK);
    wait_until(delay_ctrl_pkg::MODE_STATIC, '0);
    tap(delay_ctrl_pkg::BTN_GROW);
    // reset again in mid-run with the delay growing
    reset_i = 1'b1;
    tick(2);
    reset_i = 1'b0;
    tick(1);
    `CHK({mode_o, bypass_relay_o, delay_o}, {4'h0, 1'b1, W'(0)})
    tap(delay_ctrl_pkg::BTN_BYPASS);
    tap(delay_ctrl_pkg::BTN_BYPASS);
    wait_until(delay_ctrl_pkg::MODE_BYPASS, '0);
    // bypass shows the safe threshold at every resolution
    safe_delay_i = W'(delay_ctrl_pkg::SAFE_SAMPLES + $urandom % 96000);
    for (int r = 0; r < 4; r++) begin
      resolution_i = 2'(r);
      tick(2);
      `CHK(disp, show_exp(2'(r), safe_delay_i))
    end
    tally_and_finish();
  end
endmodule : tb_delay_mode_ctrl
